// >>> verilog/jtid_tap.sv
`timescale 1ns/1ps
// Summary of operation
// - one boundary-scan test port scanning the device pins
// - chip-tap instruction forwards the test port to the inner chip tap
// - five test clocks with tms high return the port to reset
// - identity instruction shifts version, part, maker fields, bit zero one
// - usercode instruction shifts user id, unused span, silicon revision
// - user id comes from security bits 22..31, zero when unprogrammed
// - global reset is active low and asserts without a clock
// - after reset release wait for pll lock, then boot by mode
// - security bits 31..22 hold the user id loaded during every reset
// - security bit zero disables the test port entirely
module jtid_tap import jtid_pkg::*; #(
   parameter logic [3:0]  ID_VERSION = 4'h0,     // arbitrary value
   parameter logic [15:0] ID_PART    = 16'h0001, // arbitrary value
   parameter logic [10:0] ID_MFR     = 11'h001,  // arbitrary value
   parameter logic [15:0] SI_REV     = 16'h0001  // arbitrary value
) (
   // system
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic        rst_n_in,
   // test pins
   input  wire logic        tck_in,
   input  wire logic        tms_in,
   input  wire logic        tdi_in,
   output logic             tdo_out,
   output logic             tdo_oe_n_out,
   // security register from one-time memory
   input  wire logic [31:0] security_in,
   // boundary scan cells
   input  wire logic [31:0] pins_in,
   output logic [31:0]      bscan_out,
   output logic             extest_out,
   // inner chip tap
   output jtid_chip_type    chip_out,
   input  wire logic        chip_tdo_in,
   // boot control
   input  wire logic        pll_lock_in,
   input  wire logic        boot_mode_in,
   output logic             boot_start_out,
   output logic             boot_mode_out
);
   logic [2:0]       tck_s_r;
   logic [1:0]       tms_s_r, tdi_s_r, lk_s_r, bm_s_r;
   logic [31:0]      pins_a_r, pins_b_r;
   jtid_pins_type    pin;
   jtid_state_type   st_r, st_nxt;
   jtid_boot_type    boot_r, boot_nxt;
   logic [3:0]       ir_sh_r, ir_r;
   logic [31:0]      dr_sh_r, bscan_r;
   logic             byp_r, tdo_r, oe_n_r, extest_r, bm_r;
   logic [2:0]       tms_cnt_r;
   logic [31:0]      sec_r;
   logic             rst_n_a_r, rst_n_b_r;

   // async-assert reset, sync release into clock_in
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_n_a_r <= 1'b0;
         rst_n_b_r <= 1'b0;
      end else begin
         rst_n_a_r <= 1'b1;
         rst_n_b_r <= rst_n_a_r;
      end
   end
   wire rst = sys_rst_in | ~rst_n_b_r;

   // two-flop synchronisers; third stage for edge detection
   always_ff @(posedge clock_in) begin
      tck_s_r  <= {tck_s_r[1:0], tck_in};
      tms_s_r  <= {tms_s_r[0], tms_in};
      tdi_s_r  <= {tdi_s_r[0], tdi_in};
      lk_s_r   <= {lk_s_r[0], pll_lock_in};
      bm_s_r   <= {bm_s_r[0], boot_mode_in};
      pins_a_r <= pins_in;
      pins_b_r <= pins_a_r;
   end
   assign pin = '{tck: tck_s_r[1], tms: tms_s_r[1], tdi: tdi_s_r[1]};
   wire rise = pin.tck & ~tck_s_r[2];
   wire fall = ~pin.tck & tck_s_r[2];

   // security fields
   wire jtag_off = sec_r[JTID_SEC_JTAG_OFF];
   wire [9:0] uid = sec_r[JTID_SEC_UID_LSB +: JTID_SEC_UID_W];

   // instruction decode
   function automatic logic known_ir(input logic [3:0] c);
      known_ir = (c == JTID_IR_EXTEST) || (c == JTID_IR_DEVICE_IDENTITY_WORD) ||
                 (c == JTID_IR_USERCODE) || (c == JTID_IR_CHIPTAP);
   endfunction
   wire sel_id   = ir_r == JTID_IR_DEVICE_IDENTITY_WORD;
   wire sel_uc   = ir_r == JTID_IR_USERCODE;
   wire sel_chip = (ir_r == JTID_IR_CHIPTAP) & ~jtag_off;
   wire sel_bs   = ir_r == JTID_IR_EXTEST;
   wire sel_byp  = ~known_ir(ir_r);

   // capture words
   wire [31:0] id_word = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
   wire [31:0] uc_word = {uid, 6'h00, SI_REV};
   wire [31:0] cap_word = sel_id ? id_word :
                          sel_uc ? uc_word :
                          sel_bs ? pins_b_r : 32'h00000000;

   // sixteen-state controller next state
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         TLR:    st_nxt = pin.tms ? TLR    : RTI;
         RTI:    st_nxt = pin.tms ? SEL_DR : RTI;
         SEL_DR: st_nxt = pin.tms ? SEL_IR : CAP_DR;
         CAP_DR: st_nxt = pin.tms ? EX1_DR : SH_DR;
         SH_DR:  st_nxt = pin.tms ? EX1_DR : SH_DR;
         EX1_DR: st_nxt = pin.tms ? UP_DR  : PA_DR;
         PA_DR:  st_nxt = pin.tms ? EX2_DR : PA_DR;
         EX2_DR: st_nxt = pin.tms ? UP_DR  : SH_DR;
         UP_DR:  st_nxt = pin.tms ? SEL_DR : RTI;
         SEL_IR: st_nxt = pin.tms ? TLR    : CAP_IR;
         CAP_IR: st_nxt = pin.tms ? EX1_IR : SH_IR;
         SH_IR:  st_nxt = pin.tms ? EX1_IR : SH_IR;
         EX1_IR: st_nxt = pin.tms ? UP_IR  : PA_IR;
         PA_IR:  st_nxt = pin.tms ? EX2_IR : PA_IR;
         EX2_IR: st_nxt = pin.tms ? UP_IR  : SH_IR;
         UP_IR:  st_nxt = pin.tms ? SEL_DR : RTI;
      endcase
   end
   // five-high run forces reset regardless of path
   wire tms_reset = pin.tms && (tms_cnt_r == 3'(JTID_TMS_RESET_CNT - 1));

   // tap state and shift registers, advanced on tck rising edges
   always_ff @(posedge clock_in) begin
      if (rst || jtag_off) begin
         st_r      <= TLR;
         ir_r      <= JTID_IR_RESET;
         ir_sh_r   <= JTID_IR_CAPTURE;
         dr_sh_r   <= 32'h00000000;
         byp_r     <= 1'b0;
         tms_cnt_r <= 3'h0;
         bscan_r   <= 32'h00000000;
      end else if (rise && !sel_chip) begin
         tms_cnt_r <= pin.tms ? (tms_cnt_r == 3'(JTID_TMS_RESET_CNT - 1) ?
                      tms_cnt_r : tms_cnt_r + 3'h1) : 3'h0;
         st_r <= tms_reset ? TLR : st_nxt;
         if (st_r == TLR)
            ir_r <= JTID_IR_RESET;
         if (st_r == CAP_IR)
            ir_sh_r <= JTID_IR_CAPTURE;
         if (st_r == SH_IR)
            ir_sh_r <= {pin.tdi, ir_sh_r[3:1]};
         if (st_r == UP_IR)
            ir_r <= ir_sh_r;
         if (st_r == CAP_DR) begin
            dr_sh_r <= cap_word;
            byp_r   <= 1'b0;
         end
         if (st_r == SH_DR) begin
            dr_sh_r <= {pin.tdi, dr_sh_r[31:1]};
            byp_r   <= pin.tdi;
         end
         if (st_r == UP_DR && sel_bs)
            bscan_r <= dr_sh_r;
      end else if (rise && sel_chip) begin
         // chip tap owns the chain until a five-high reset
         tms_cnt_r <= pin.tms ? (tms_cnt_r == 3'(JTID_TMS_RESET_CNT - 1) ?
                      tms_cnt_r : tms_cnt_r + 3'h1) : 3'h0;
         if (tms_reset) begin
            st_r <= TLR;
            ir_r <= JTID_IR_RESET;
         end
      end
   end

   // tdo launched on falling tck edge; chip tap output forwarded every clock while selected
   wire shifting = (st_r == SH_DR) || (st_r == SH_IR);
   wire tdo_src  = (st_r == SH_IR) ? ir_sh_r[0] :
                   sel_byp ? byp_r : dr_sh_r[0];
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tdo_r  <= 1'b0;
         oe_n_r <= 1'b1;
      end else if (rst || jtag_off) begin
         tdo_r  <= 1'b0;
         oe_n_r <= 1'b1;
      end else if (sel_chip) begin
         tdo_r  <= chip_tdo_in;
         oe_n_r <= 1'b0;
      end else if (fall) begin
         tdo_r  <= tdo_src;
         oe_n_r <= ~shifting;
      end
   end

   // security register reloaded every clock while in reset, held after release
   always_ff @(posedge clock_in) begin
      if (rst)
         sec_r <= security_in;
      else
         sec_r <= sec_r;
   end

   // boot sequencer
   always_comb begin
      boot_nxt = boot_r;
      unique case (boot_r)
         BOOT_RESET:     boot_nxt = BOOT_WAIT_LOCK;
         BOOT_WAIT_LOCK: boot_nxt = lk_s_r[1] ? BOOT_RUN : BOOT_WAIT_LOCK;
         BOOT_RUN:       boot_nxt = BOOT_RUN;
         default:        boot_nxt = BOOT_RESET;
      endcase
   end
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         boot_r <= BOOT_RESET;
         bm_r   <= 1'b0;
      end else if (rst) begin
         boot_r <= BOOT_RESET;
         bm_r   <= 1'b0;
      end else begin
         boot_r <= boot_nxt;
         if (boot_r == BOOT_WAIT_LOCK && lk_s_r[1])
            bm_r <= bm_s_r[1];
      end
   end
   always_ff @(posedge clock_in) begin
      extest_r <= ~rst & sel_bs & ~jtag_off;
   end

   // outputs
   assign tdo_out        = tdo_r;
   assign tdo_oe_n_out   = oe_n_r;
   assign bscan_out      = bscan_r;
   assign extest_out     = extest_r;
   assign chip_out       = '{sel: sel_chip, tck_rise: rise & sel_chip,
                             tms: pin.tms, tdi: pin.tdi};
   assign boot_start_out = boot_r == BOOT_RUN;
   assign boot_mode_out  = bm_r;

   // assertions
   property p_tms_reset;
      @(posedge clock_in) disable iff (rst || jtag_off)
      (rise && tms_reset) |=> st_r == TLR;
   endproperty
   a_tms_reset: assert property (p_tms_reset)
      else $error("tap not in reset after five tms high");
   property p_device_identity_word;
      @(posedge clock_in) disable iff (rst || jtag_off)
      (rise && !sel_chip && st_r == CAP_DR && sel_id) |=>
         dr_sh_r == id_word && dr_sh_r[0];
   endproperty
   a_device_identity_word: assert property (p_device_identity_word)
      else $error("identity word not captured");
   property p_usercode;
      @(posedge clock_in) disable iff (rst || jtag_off)
      (rise && !sel_chip && st_r == CAP_DR && sel_uc) |=>
         dr_sh_r[31:22] == $past(sec_r[31:22]);
   endproperty
   a_usercode: assert property (p_usercode)
      else $error("user id not from security bits");
   property p_jtag_off;
      @(posedge clock_in) disable iff (rst)
      jtag_off |=> oe_n_r && st_r == TLR && !chip_out.sel;
   endproperty
   a_jtag_off: assert property (p_jtag_off)
      else $error("test port active while disabled");
   property p_bypass;
      @(posedge clock_in) disable iff (rst || jtag_off)
      (rise && st_r == SH_DR && sel_byp) |=> byp_r == $past(pin.tdi);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass bit not loaded");
   property p_ir_shift;
      @(posedge clock_in) disable iff (rst || jtag_off)
      (rise && !sel_chip && st_r == SH_IR) |=>
         ir_sh_r[3] == $past(pin.tdi);
   endproperty
   a_ir_shift: assert property (p_ir_shift)
      else $error("instruction shift wrong");
   property p_boot;
      @(posedge clock_in) disable iff (rst)
      boot_start_out |-> $past(lk_s_r[1]) || $past(boot_start_out);
   endproperty
   a_boot: assert property (p_boot)
      else $error("boot started without pll lock");
   property p_chip;
      @(posedge clock_in) disable iff (rst || jtag_off)
      sel_chip |=> tdo_r == $past(chip_tdo_in) && !oe_n_r;
   endproperty
   a_chip: assert property (p_chip)
      else $error("chip tap output not forwarded");
endmodule

// >>> verilog/jtid_pkg.sv
package jtid_pkg;
   // instruction codes (4-bit instruction register)
   localparam int          JTID_IR_W        = 4;
   localparam int          JTID_DR_W        = 32;
   localparam logic [3:0]  JTID_IR_EXTEST   = 4'h0;
   localparam logic [3:0]  JTID_IR_DEVICE_IDENTITY_WORD   = 4'h1;
   localparam logic [3:0]  JTID_IR_USERCODE = 4'h2;
   localparam logic [3:0]  JTID_IR_CHIPTAP  = 4'h3;
   localparam logic [3:0]  JTID_IR_BYPASS   = 4'hF;
   localparam logic [3:0]  JTID_IR_RESET    = JTID_IR_DEVICE_IDENTITY_WORD;
   // capture value of the instruction register
   localparam logic [3:0]  JTID_IR_CAPTURE  = 4'h1;
   // identity word fields
   localparam int          JTID_ID_VER_LSB  = 28;
   localparam int          JTID_ID_PART_LSB = 12;
   localparam int          JTID_ID_MFR_LSB  = 1;
   // usercode word fields
   localparam int          JTID_UC_UID_LSB  = 22;
   localparam int          JTID_UC_REV_W    = 16;
   // security register bit positions
   localparam int          JTID_SEC_JTAG_OFF = 0;
   localparam int          JTID_SEC_UID_LSB  = 22;
   localparam int          JTID_SEC_UID_W    = 10;
   // tms high run that forces reset
   localparam int          JTID_TMS_RESET_CNT = 5;
   // external reset minimum low time
   localparam int          JTID_RST_MIN_NS  = 100;
   localparam int          JTID_CLK_NS      = 40;
   localparam int          JTID_RST_MIN_CYC =
      (JTID_RST_MIN_NS + JTID_CLK_NS - 1) / JTID_CLK_NS;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
   } jtid_state_type;

   typedef enum logic [1:0] {
      BOOT_RESET, BOOT_WAIT_LOCK, BOOT_RUN
   } jtid_boot_type;

   // test pins after synchronisation
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } jtid_pins_type;

   // forwarded chip tap signals
   typedef struct packed {
      logic sel;
      logic tck_rise;
      logic tms;
      logic tdi;
   } jtid_chip_type;
endpackage

// >>> tb/jtid_dbg.sv
`timescale 1ns/1ps
// debugger model driving the test pins
module jtid_dbg (
   // system
   input  wire logic clock_in,
   // test pins
   input  wire logic tdo_in,
   output logic      tck_out,
   output logic      tms_out,
   output logic      tdi_out
);
   // test clock parked low between frames
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end
   // one test clock, 8 system clocks; tdo taken just before the fall
   task automatic step(input logic ms, input logic di, output logic dq);
      tms_out = ms;
      tdi_out = di;
      repeat (4) @(negedge clock_in);
      tck_out = 1'b1;
      repeat (4) @(negedge clock_in);
      dq = tdo_in;
      tck_out = 1'b0;
   endtask
   // five tms-high clocks, then idle
   task automatic reset5();
      logic dq;
      repeat (5) step(1'b1, 1'b0, dq);
      step(1'b0, 1'b0, dq);
   endtask
   // idle to shift to update to idle, lsb first
   task automatic scan(input logic ir, input int n,
                       input logic [31:0] d, output logic [31:0] q);
      logic dq;
      q = '0;
      step(1'b1, 1'b0, dq);
      if (ir) step(1'b1, 1'b0, dq);
      step(1'b0, 1'b0, dq);
      step(1'b0, 1'b0, dq);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, d[i], dq);
         q[i] = dq;
      end
      step(1'b1, 1'b0, dq);
      step(1'b0, 1'b0, dq);
   endtask
endmodule

// >>> tb/tb_jtag_tap_with_id_registers.sv
`timescale 1ns/1ps
module tb_jtag_tap_with_id_registers;
   import jtid_pkg::*;
   typedef struct packed {
      logic [3:0]  code;
      logic [31:0] din;
      logic [31:0] exp;
   } jtid_row_type;
   logic          clock_in, sys_rst_in, rst_n_in, tck, tms, tdi, tdo;
   logic          tdo_oe_n, extest, pll_lock, boot_mode, boot_start;
   logic          boot_mode_o, chip_tdo;
   logic [31:0]   security, bscan, q;
   jtid_chip_type chip;
   int            n_mismatch, total_checks, d0;
   int            n_drive = 0, n_ctms = 0, n_ctdi = 0;
   // released data pin shows the inverse of tdo, which still updates on falling tck edges except in reset or with the port disabled
   wire           tdo_pin = (tdo_oe_n === 1'b0) ? tdo : ~tdo;
   // code, shifted in, expected out
   jtid_row_type  rows [5] = '{
      '{4'h1, 32'h0, 32'h0000_1003},
      '{4'h2, 32'h0, 32'hA940_0001},
      '{4'hF, 32'h8000_0001, 32'h0000_0002},
      '{4'h7, 32'hC000_0003, 32'h8000_0006},
      '{4'h0, 32'h1234_5678, 32'h5A5A_0FF0}};

   jtid_tap uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
      .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .security_in(security),
      .pins_in(32'h5A5A_0FF0), .bscan_out(bscan), .extest_out(extest),
      .chip_out(chip), .chip_tdo_in(chip_tdo), .pll_lock_in(pll_lock),
      .boot_mode_in(boot_mode), .boot_start_out(boot_start),
      .boot_mode_out(boot_mode_o));
   jtid_dbg u_dbg (.clock_in(clock_in), .tdo_in(tdo_pin), .tck_out(tck),
      .tms_out(tms), .tdi_out(tdi));

   // 25 MHz system clock
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   // counts drive cycles and forwarded inner tap clocks
   always @(negedge clock_in) begin
      if (tdo_oe_n === 1'b0) n_drive++;
      if (chip.tck_rise === 1'b1 && chip.tms === 1'b1) n_ctms++;
      if (chip.tck_rise === 1'b1 && chip.tdi === 1'b1) n_ctdi++;
   end
   // hang guard
   initial begin
      #1_000_000;
      n_mismatch++;
      finish_test();
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time,
                  seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // both resets held 4 clocks (160 ns), then tap to idle
   task automatic hw_reset();
      @(negedge clock_in);
      sys_rst_in = 1'b1;
      rst_n_in = 1'b0;
      repeat (4) @(negedge clock_in);
      sys_rst_in = 1'b0;
      rst_n_in = 1'b1;
      repeat (6) @(negedge clock_in);
      u_dbg.reset5();
   endtask

   // main sequence
   initial begin
      sys_rst_in = 1'b1;
      rst_n_in = 1'b0;
      security = 32'hA940_0000;
      pll_lock = 1'b0;
      boot_mode = 1'b0;
      chip_tdo = 1'b1;
      n_mismatch = 0;
      total_checks = 0;
      hw_reset();
      check(boot_start, 0);
      boot_mode = 1'b1;
      pll_lock = 1'b1;
      for (int i = 0; i < 10 && boot_start !== 1'b1; i++)
         @(negedge clock_in);
      check(boot_start, 1);
      check(boot_mode_o, 1);
      foreach (rows[k]) begin
         d0 = n_drive;
         u_dbg.scan(1'b1, 4, rows[k].code, q);
         check(q, {28'h0, JTID_IR_CAPTURE});
         u_dbg.scan(1'b0, 32, rows[k].din, q);
         check(q, rows[k].exp);
         check(n_drive > d0, 1);
         if (rows[k].code == JTID_IR_EXTEST) begin
            check(bscan, rows[k].din);
            check(extest, 1);
         end
      end
      // inner tap forwarding, left again by the tms run
      u_dbg.scan(1'b1, 4, JTID_IR_CHIPTAP, q);
      check(chip.sel, 1);
      check(tdo_oe_n, 0);
      chip_tdo = 1'b0;
      repeat (2) @(negedge clock_in);
      check(tdo, 0);
      chip_tdo = 1'b1;
      repeat (2) @(negedge clock_in);
      check(tdo, 1);
      u_dbg.step(1'b0, 1'b1, q[0]);
      u_dbg.reset5();
      check(n_ctms, 5);
      check(n_ctdi, 1);
      check(chip.sel, 0);
      u_dbg.scan(1'b0, 32, 32'h0, q);
      check(q, 32'h0000_1003);
      // global reset acts before any clock edge
      u_dbg.scan(1'b1, 4, JTID_IR_CHIPTAP, q);
      rst_n_in = 1'b0;
      #1;
      check(tdo_oe_n, 1);
      check(boot_start, 0);
      // unprogrammed one-time memory gives a zero user id
      security = 32'h0;
      hw_reset();
      u_dbg.scan(1'b1, 4, JTID_IR_USERCODE, q);
      u_dbg.scan(1'b0, 32, 32'h0, q);
      check(q, 32'h0000_0001);
      // disable bit locks the port out, inner tap included
      security = 32'h0000_0001;
      hw_reset();
      d0 = n_drive;
      u_dbg.scan(1'b1, 4, JTID_IR_CHIPTAP, q);
      u_dbg.scan(1'b0, 32, 32'h0, q);
      check(n_drive - d0, 0);
      check(chip.sel, 0);
      finish_test();
   end
endmodule
